/* File: alu_skip_branch_map.vh */
`ifndef ALU_SKIP_BRANCH_MAP_VH
`define ALU_SKIP_BRANCH_MAP_VH
// ----------------------------------------
// Operation codes on the op_code port
// ----------------------------------------
`define OP_NONE                  3'h0
`define OP_CLEAR_ACCUMULATOR     3'h1
`define OP_DECREMENT_SKIP        3'h2
`define OP_INCREMENT_SKIP        3'h3
`define OP_JUMP_ABSOLUTE         3'h4
`define OP_OR_LITERAL            3'h5
`define OP_INCREMENT_REGISTER    3'h6
`define OP_OR_REGISTER           3'h7
// ----------------------------------------
// Field positions and reset values
// ----------------------------------------
`define LATCH_JUMP_HI            4
`define LATCH_JUMP_LO            3
`define ACC_RESET                8'h00
`define ZERO_RESET               1'b0
`define PC_RESET                 13'h0000
// ----------------------------------------
// Cycle counts
// ----------------------------------------
`define TWO_CYCLE_STALL          1'b1
`endif

/* File: alu_result_unit.v */
`timescale 1ns/1ns
module alu_result_unit (
   // Operation and operands
   input  wire [2:0] op_code,
   input  wire [7:0] acc_value,
   input  wire [7:0] file_value,
   input  wire [7:0] literal,
   // Result
   output reg  [7:0] result,
   output reg        result_zero
);
`include "alu_skip_branch_map.vh"
   always @* begin
      case (op_code)
         `OP_CLEAR_ACCUMULATOR:  result = 8'h00;
         `OP_DECREMENT_SKIP:     result = file_value - 8'h01;
         `OP_INCREMENT_SKIP,
         `OP_INCREMENT_REGISTER: result = file_value + 8'h01;
         `OP_OR_LITERAL:         result = acc_value | literal;
         `OP_OR_REGISTER:        result = acc_value | file_value;
         default:                result = acc_value;
      endcase
      result_zero = (result == 8'h00);
   end
endmodule

/* File: alu_skip_branch_ops.v */
// Functional notes
// - Clear accumulator to zero and set the zero flag; no operands.
// - Destination bit 0 writes accumulator, 1 writes file register 0..127.
// - Decrement-skip stores per destination, flags unchanged; zero result skips next.
// - Increment-skip stores per destination, flags unchanged; zero result skips next.
// - Jump loads immediate into counter 10:0, latch bits 4:3 into 12:11.
// - Jump is unconditional, immediate 0..2047, flags unchanged, two cycles.
// - OR literal into accumulator and update zero flag.
// - Increment register stores per destination, updates zero flag, no skip.
// - OR accumulator with register, store per destination, update zero flag.
`timescale 1ns/1ns
module alu_skip_branch_ops #(
   parameter ADDR_W = 7
) (
   // Clock and reset
   input  wire              core_clk,
   input  wire              rst,
   // Instruction issue
   input  wire              op_valid,
   input  wire [2:0]        op_code,
   input  wire              dest_bit,
   input  wire [ADDR_W-1:0] file_addr,
   input  wire [10:0]       immediate,
   input  wire [7:0]        upper_jump_latch,
   // File register port
   input  wire [7:0]        file_rdata,
   output wire [ADDR_W-1:0] file_waddr,
   output reg  [7:0]        file_wdata,
   output reg               file_we,
   // Core state
   output reg  [7:0]        acc_q,
   output reg               zero_flag_q,
   output reg  [12:0]       program_counter_q,
   output reg               jump_q,
   output reg               squash_q,
   output wire              op_ready
);
`include "alu_skip_branch_map.vh"
   // ----------------------------------------
   // Decode helpers
   // ----------------------------------------
   // Skip ops are the only ones whose length depends on data.
   function is_skip_op;
      input [2:0] code;
      begin
         is_skip_op = (code == `OP_DECREMENT_SKIP) || (code == `OP_INCREMENT_SKIP);
      end
   endfunction
   // File ops that honour the destination bit.
   function has_dest;
      input [2:0] code;
      begin
         case (code)
            `OP_DECREMENT_SKIP,
            `OP_INCREMENT_SKIP,
            `OP_INCREMENT_REGISTER,
            `OP_OR_REGISTER: has_dest = 1'b1;
            default:         has_dest = 1'b0;
         endcase
      end
   endfunction
   // Ops that rewrite the zero flag; skip ops and the jump leave it alone.
   function updates_zero;
      input [2:0] code;
      begin
         case (code)
            `OP_CLEAR_ACCUMULATOR,
            `OP_OR_LITERAL,
            `OP_INCREMENT_REGISTER,
            `OP_OR_REGISTER: updates_zero = 1'b1;
            default:         updates_zero = 1'b0;
         endcase
      end
   endfunction
   // Jump target: two latch bits above the eleven-bit immediate.
   function [12:0] jump_target;
      input [7:0]  latch;
      input [10:0] target;
      begin
         jump_target = {latch[`LATCH_JUMP_HI:`LATCH_JUMP_LO], target};
      end
   endfunction
   // ----------------------------------------
   // Result path
   // ----------------------------------------
   wire [7:0] result;
   wire       result_zero;
   reg  [7:0] acc_d;
   reg        zero_flag_d;
   reg [12:0] program_counter_d;
   reg        jump_d;
   reg        squash_d;
   reg        busy_q;
   reg        busy_d;
   // ----------------------------------------
   // Operand unit
   // ----------------------------------------
   alu_result_unit u_result (
      .op_code     (op_code),
      .acc_value   (acc_q),
      .file_value  (file_rdata),
      .literal     (immediate[7:0]),
      .result      (result),
      .result_zero (result_zero)
   );
   // ----------------------------------------
   // File port
   // ----------------------------------------
   // Read data must settle within the cycle; it feeds the write data directly.
   assign file_waddr = file_addr;
   // ----------------------------------------
   // Issue handshake
   // ----------------------------------------
   // The second cycle of a two-cycle op refuses a new issue.
   assign op_ready = ~busy_q;
   wire take = op_valid & ~busy_q;
   // ----------------------------------------
   // Decoded issue
   // ----------------------------------------
   // The write strobe is decoded apart from the case below so that the
   // file port sees it without waiting on the accumulator path.
   wire to_file    = take & has_dest(op_code) & dest_bit;
   wire skip_taken = take & is_skip_op(op_code) & result_zero;
   // ----------------------------------------
   // Next state
   // ----------------------------------------
   always @* begin
      acc_d             = acc_q;
      zero_flag_d       = zero_flag_q;
      program_counter_d = program_counter_q;
      jump_d            = 1'b0;
      squash_d          = 1'b0;
      busy_d            = 1'b0;
      file_wdata        = result;
      file_we           = to_file;
      if (take) begin
         program_counter_d = program_counter_q + 13'h0001;
         case (op_code)
            `OP_CLEAR_ACCUMULATOR: begin
               acc_d       = 8'h00;
               zero_flag_d = 1'b1;
            end
            `OP_DECREMENT_SKIP: begin
               if (!dest_bit)
                  acc_d = result;
            end
            `OP_INCREMENT_SKIP: begin
               if (!dest_bit)
                  acc_d = result;
            end
            `OP_JUMP_ABSOLUTE: begin
               program_counter_d = jump_target(upper_jump_latch, immediate);
               jump_d            = 1'b1;
               busy_d            = `TWO_CYCLE_STALL;
            end
            `OP_OR_LITERAL: begin
               acc_d = result;
            end
            `OP_INCREMENT_REGISTER: begin
               if (!dest_bit)
                  acc_d = result;
            end
            `OP_OR_REGISTER: begin
               if (!dest_bit)
                  acc_d = result;
            end
            default: begin
               acc_d = acc_q;
            end
         endcase
         if (updates_zero(op_code))
            zero_flag_d = result_zero;
         // Skip ops keep the flags; only the slot after them is lost.
         if (skip_taken) begin
            squash_d = 1'b1;
            busy_d   = `TWO_CYCLE_STALL;
         end
      end
   end
   // ----------------------------------------
   // Accumulator and zero flag
   // ----------------------------------------
   always @(posedge core_clk or posedge rst) begin
      if (rst) begin
         acc_q       <= `ACC_RESET;
         zero_flag_q <= `ZERO_RESET;
      end else begin
         acc_q       <= acc_d;
         zero_flag_q <= zero_flag_d;
      end
   end
   // ----------------------------------------
   // Program counter
   // ----------------------------------------
   // The top two counter bits are loaded from the latch on a jump, and can also change by carry out of the increment.
   always @(posedge core_clk or posedge rst) begin
      if (rst) begin
         program_counter_q <= `PC_RESET;
      end else begin
         program_counter_q <= program_counter_d;
      end
   end
   // ----------------------------------------
   // Issue control
   // ----------------------------------------
   // Busy is the only state that throttles issue; it never lasts past one cycle.
   always @(posedge core_clk or posedge rst) begin
      if (rst) begin
         jump_q   <= 1'b0;
         squash_q <= 1'b0;
         busy_q   <= 1'b0;
      end else begin
         jump_q   <= jump_d;
         squash_q <= squash_d;
         busy_q   <= busy_d;
      end
   end
endmodule

/* File: alu_skip_branch_props.sv */
`timescale 1ns/1ns
`include "alu_skip_branch_map.vh"
module alu_skip_branch_props (
   input logic        core_clk, rst, op_valid, op_ready, dest_bit, file_we, zero_flag_q, jump_q, squash_q,
   input logic [2:0]  op_code,
   input logic [7:0]  file_rdata, file_wdata, acc_q, upper_jump_latch,
   input logic [10:0] immediate,
   input logic [12:0] program_counter_q
);
   wire tk = op_valid & op_ready;
   default clocking @(posedge core_clk); endclocking
   default disable iff (rst);
   property p_clr; tk && op_code == `OP_CLEAR_ACCUMULATOR |=> acc_q == 8'h00 && zero_flag_q; endproperty
   a_clr: assert property (p_clr) else $error("clear failed");
   property p_we; tk && dest_bit && op_code == `OP_INCREMENT_REGISTER |-> file_we && file_wdata == file_rdata + 8'h01;
   endproperty
   a_we: assert property (p_we) else $error("register write wrong");
   property p_dec; tk && op_code == `OP_DECREMENT_SKIP |=> $stable(zero_flag_q); endproperty
   a_dec: assert property (p_dec) else $error("flag moved");
   property p_inc; tk && op_code == `OP_INCREMENT_SKIP && file_rdata == 8'hff |=> squash_q && !op_ready; endproperty
   a_inc: assert property (p_inc) else $error("no skip");
   property p_jmp; tk && op_code == `OP_JUMP_ABSOLUTE |=> jump_q && !op_ready &&
      program_counter_q == {$past(upper_jump_latch[4:3]), $past(immediate)} ##1 op_ready; endproperty
   a_jmp: assert property (p_jmp) else $error("jump wrong");
   property p_orl; tk && op_code == `OP_OR_LITERAL |=> acc_q == ($past(acc_q) | $past(immediate[7:0])); endproperty
   a_orl: assert property (p_orl) else $error("or literal wrong");
   property p_zero; tk && op_code == `OP_OR_REGISTER && !dest_bit |=> zero_flag_q == (acc_q == 8'h00); endproperty
   a_zero: assert property (p_zero) else $error("zero flag wrong");
   property p_nskip; tk && op_code == `OP_DECREMENT_SKIP && file_rdata != 8'h01 |=> !squash_q && op_ready;
   endproperty
   a_nskip: assert property (p_nskip) else $error("false skip");
   c_jump: cover property (jump_q);
   c_skip: cover property (squash_q);
   c_we: cover property (file_we);
endmodule

/* File: test_alu_skip_branch_ops.sv */
`timescale 1ns/1ns
`include "alu_skip_branch_map.vh"
module test_alu_skip_branch_ops;
   logic        core_clk = 0, rst = 1, op_valid = 0, dest_bit = 0, ez = 0;
   logic        file_we, jump_q, squash_q, op_ready, zero_flag_q;
   logic [2:0]  op_code = 0;
   logic [6:0]  file_addr = 0, file_waddr;
   logic [10:0] immediate = 0;
   logic [7:0]  upper_jump_latch = 0, file_rdata = 0, file_wdata, acc_q, ea = 0;
   logic [12:0] program_counter_q, epc = 0;
   logic [31:0] seed = 32'h00e4;
   int          errors = 0, cmp_count = 0;
   always #2 core_clk = ~core_clk;
   alu_skip_branch_ops i_dut (.*);
   function automatic [31:0] lfsr(input [31:0] s);
      lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   task automatic chk(input string n, input [12:0] e, g);
      cmp_count++;
      if (g !== e) begin
         errors++;
         $display("ERROR %s exp %h got %h", n, e, g);
      end
   endtask
   task automatic end_of_test;
      if (errors == 0 && cmp_count > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   task automatic run(input [2:0] op, input d, input [7:0] f, input [10:0] k, input [7:0] lat);
      logic [7:0] r;
      logic       w, sk;
      for (int i = 0; !op_ready; i++) begin
         if (i > 3) begin
            errors++;
            end_of_test;
         end
         @(negedge core_clk);
      end
      {op_valid, op_code, dest_bit, file_rdata, immediate, upper_jump_latch} = {1'b1, op, d, f, k, lat};
      file_addr = k[6:0];
      r = op == 1 ? 8'h00 : op == 2 ? f - 8'h01 : op == 5 ? ea | k[7:0] : op == 7 ? ea | f : op == 4 ? ea : f + 8'h01;
      w = d && op inside {2, 3, 6, 7};
      sk = op inside {2, 3} && r == 8'h00;
      #1;
      chk("we", w, file_we);
      chk("waddr", k[6:0], file_waddr);
      if (w) chk("wdata", r, file_wdata);
      if (!w && op != 4) ea = r;
      if (op inside {1, 5, 6, 7}) ez = r == 8'h00;
      epc = op == 4 ? {lat[4:3], k} : epc + 13'h0001;
      @(negedge core_clk);
      op_valid = 0;
      chk("acc", ea, acc_q);
      chk("zero", ez, zero_flag_q);
      chk("pc", epc, program_counter_q);
      chk("skip", sk, squash_q);
      chk("jump", op == 4, jump_q);
      chk("ready", !(sk || op == 4), op_ready);
   endtask
   initial begin
      repeat (2) @(negedge core_clk);
      rst = 0;
      run(`OP_DECREMENT_SKIP, 1, 8'h01, 0, 0);
      run(`OP_INCREMENT_SKIP, 0, 8'hff, 0, 0);
      run(`OP_JUMP_ABSOLUTE, 0, 0, 11'h7ff, 8'h18);
      run(`OP_CLEAR_ACCUMULATOR, 0, 0, 0, 0);
      // Read data is biased to 01 and ff so that skips are taken often.
      repeat (300) begin
         seed = lfsr(seed);
         run(seed[2:0] ? seed[2:0] : 3'h1, seed[5], seed[3] ? seed[15:8] : seed[4] ? 8'h01 : 8'hff,
             seed[26:16], seed[31:24]);
      end
      end_of_test;
   end
endmodule
bind alu_skip_branch_ops alu_skip_branch_props u_props (.*);
